// [verif/lcb_core_properties.sv]
module lcb_core_properties
   import lcb_pkg::*;
#(
   parameter int COLS = 80
) (
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   input wire logic BYTE_READY_OUT,
   input wire logic ACK_VALID_OUT,
   input wire logic ACK_OUT,
   input wire logic ACK_READY_IN,
   input wire logic DISP_TICK_IN,
   input wire logic [1:0] BACKPLANE_OUTPUT_SEL_OUT,
   input wire logic [1:0] RAM_ROW_OUT,
   input wire logic [COLS-1:0] SEGMENT_OUTPUT_OUT,
   input wire logic DISPLAY_ON_OUT,
   input wire logic [1:0] DRIVE_MODE_OUT,
   input wire logic [6:0] POINTER_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   // One clock domain, all checks except a_reset_clear quiet in reset
   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (SRST_IN);
   a_reset_clear:
      assert property (disable iff (1'b0) SRST_IN |=> POINTER_OUT == 7'h00
         && DRIVE_MODE_OUT == 2'h0) else $error("reset state wrong");
   a_ack_hold:
      assert property (ACK_VALID_OUT && !ACK_READY_IN |=> ACK_VALID_OUT && $stable(ACK_OUT))
      else $error("ack not held");
   a_static_row:
      assert property (DISP_TICK_IN && DRIVE_MODE_OUT == 2'h1 |=> BACKPLANE_OUTPUT_SEL_OUT == 2'h0)
      else $error("static row");
   a_tri_rows:
      assert property (DISP_TICK_IN && DRIVE_MODE_OUT == 2'h3 |=> BACKPLANE_OUTPUT_SEL_OUT != 2'h3)
      else $error("tri row");
   a_quad_step:
      assert property (DISP_TICK_IN && DRIVE_MODE_OUT == 2'h0 |=>
         BACKPLANE_OUTPUT_SEL_OUT == $past(BACKPLANE_OUTPUT_SEL_OUT) + 2'h1)
      else $error("quad step");
   a_row_hold:
      assert property (!DISP_TICK_IN |=> $stable(BACKPLANE_OUTPUT_SEL_OUT))
      else $error("row moved off tick");
   a_no_bank_multi:
      assert property (DRIVE_MODE_OUT[1] == DRIVE_MODE_OUT[0] |=>
         RAM_ROW_OUT == $past(BACKPLANE_OUTPUT_SEL_OUT)) else $error("bank in 1:3/1:4");
   a_static_bank:
      assert property (DRIVE_MODE_OUT == 2'h1 && BACKPLANE_OUTPUT_SEL_OUT == 2'h0 |=>
         !RAM_ROW_OUT[0]) else $error("static row odd");
   a_blank_off:
      assert property (!DISPLAY_ON_OUT [*2] |-> SEGMENT_OUTPUT_OUT == '0)
      else $error("blank shows segments");
   // Main scenarios reached
   c_full: cover property (!BYTE_READY_OUT);
   c_nack: cover property (ACK_VALID_OUT && !ACK_OUT);
   c_alt: cover property (DRIVE_MODE_OUT == 2'h1 && RAM_ROW_OUT == 2'h2);
endmodule

bind lcb_core lcb_core_properties #(.COLS(COLS)) u_props (.SYS_CLK_IN, .SRST_IN,
   .BYTE_READY_OUT, .ACK_VALID_OUT, .ACK_OUT, .ACK_READY_IN, .DISP_TICK_IN,
   .BACKPLANE_OUTPUT_SEL_OUT, .RAM_ROW_OUT, .SEGMENT_OUTPUT_OUT, .DISPLAY_ON_OUT,
   .DRIVE_MODE_OUT, .POINTER_OUT);

// [verif/lcb_core_tb.sv]
module lcb_core_tb import lcb_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, tick = 0, last = 1, vld, rdy, akv, ak, akr, ph, don, bh;
   logic [2:0] hw = 3'h0, sub;
   logic [1:0] bps, row, dm, m = 2'h0;
   logic [79:0] seg;
   logic [6:0] ptr;
   logic [3:0] ram[80];
   lcb_byte_t bt;
   logic expq[$], ph_q = 0;
   int num_errors = 0, compares = 0, p = 0, s = 0, tc = 0, half = 0, tg = 0;
   bit inb = 0, drop = 0;
   lcb_core #(.BLINK_DIV(8)) uut (.SYS_CLK_IN(clk), .SRST_IN(rst), .BYTE_VALID_IN(vld),
      .BYTE_DATA_IN(bt.data), .BYTE_FIRST_IN(bt.first), .BYTE_READY_OUT(rdy),
      .ACK_VALID_OUT(akv), .ACK_OUT(ak), .ACK_READY_IN(akr), .HW_SUBADDR_IN(hw),
      .CASCADE_LAST_IN(last), .DISP_TICK_IN(tick), .BACKPLANE_OUTPUT_SEL_OUT(bps),
      .RAM_ROW_OUT(row), .SEGMENT_OUTPUT_OUT(seg), .DISPLAY_ON_OUT(don),
      .BLINK_PHASE_OUT(ph), .DRIVE_MODE_OUT(dm), .BIAS_HALF_OUT(bh), .POINTER_OUT(ptr),
      .SUBADDR_OUT(sub));
   lcb_master_model mm (.clk_in(clk), .rst_in(rst), .ready_in(rdy), .ack_valid_in(akv),
      .ack_in(ak), .byte_out(bt), .valid_out(vld), .ack_ready_out(akr));
   // Clock, random display ticks, blink half-period meter
   initial forever #50 clk = ~clk;
   always @(negedge clk) tick <= ($urandom % 2 == 0);
   // Meter reads the settled phase and the tick the design just used
   always @(negedge clk) begin
      if (ph !== ph_q) begin half = tc; tc = 0; tg++; end
      if (tick) tc++;
      ph_q = ph;
   end
   task automatic chk(input logic [79:0] a, input logic [79:0] e);
      compares++;
      if (a !== e) begin
         num_errors++;
         $display("[ERR] %0t got %0h exp %0h", $time, a, e);
      end
   endtask
   task automatic xf(input logic f, input logic [7:0] d, input logic e);
      mm.tx_q.push_back({f, d});
      expq.push_back(e);
   endtask
   // Wait for every ack, then compare them in order
   task automatic sync();
      int n;
      n = 0;
      while (mm.acks_q.size() < expq.size() && n < 3000) begin @(negedge clk); n++; end
      repeat (3) @(negedge clk);
      chk(mm.acks_q.size(), expq.size());
      while (expq.size() > 0 && mm.acks_q.size() > 0) begin
         if (expq[0] !== 1'bx) chk(mm.acks_q[0], expq[0]);
         void'(expq.pop_front());
         void'(mm.acks_q.pop_front());
      end
      expq.delete();
      mm.acks_q.delete();
   endtask
   task automatic cmd(input logic [7:0] c);
      drop = 0;
      xf(1, 8'h00, 1);
      xf(0, c, 1);
      if (c[7:4] == 4'hC) m = c[1:0];
      if (!c[7]) p = c[6:0];
      if (c[7:3] == 5'h1C) s = c[2:0];
      if (c[7:2] == 6'h3E && m[0] != m[1]) inb = c[1];
      sync();
   endtask
   // Expected RAM image, pointer and ack of one display byte
   task automatic dat(input logic [7:0] b, input bit f);
      int n, bs, st;
      bit hit, ov, wh;
      if (f) drop = 0;
      n = (m == 2'h0) ? 4 : int'(m);
      bs = (m[0] ^ m[1] && inb) ? 2 : 0;
      st = (n + 7) / n;
      hit = (s == hw) && !drop;
      // Next device in the chain takes the bits past the last column
      wh = ((s + 1) % 8 == hw) && (p + st > 80);
      for (int i = 0; i < 8; i++)
         if (hit && p + i / n < 80) ram[p + i / n][bs + i % n] = b[7 - i];
         else if (wh && p + i / n >= 80) ram[p + i / n - 80][bs + i % n] = b[7 - i];
      p += st;
      ov = p >= 80;
      if (ov) begin p -= 80; s = (s + 1) % 8; drop = hit && last; end
      if (f) xf(1, 8'h40, 1);
      xf(0, b, hit || wh);
   endtask
   task automatic seg_chk(input logic [1:0] r);
      logic [79:0] e;
      int n;
      n = 0;
      repeat (20) @(negedge clk);
      while (row !== r && n < 400) begin @(negedge clk); n++; end
      foreach (e[c]) e[c] = ram[c][r];
      chk(row, r);
      chk(seg, e);
   endtask
   task automatic give_verdict();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      #(100 * 60000);
      num_errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h5EAF));
      foreach (ram[i]) ram[i] = 4'h0;
      last = $urandom % 2;
      repeat (10) @(negedge clk);
      rst = 0;
      mm.stall = 1;
      chk({dm, ptr, sub, don}, 0);
      for (int i = 0; i < 8; i++) begin
         cmd({4'hC, 1'b1, i[2:0]});
         chk({dm, bh}, {i[1:0], i[2]});
      end
      for (int i = 0; i < 4; i++) begin
         cmd({1'b0, 7'($urandom % 80)});
         cmd({5'h1C, 3'($urandom)});
         chk({ptr, sub}, {7'(p), 3'(s)});
      end
      cmd(8'hD5);
      cmd(8'hFC);
      cmd(8'hE9);
      chk({dm, ptr, sub}, {m, 7'(p), 3'(s)});
      hw = 3'($urandom);
      for (int k = 0; k < 4; k++) begin
         cmd({6'h32, k[1:0]});
         cmd({5'h1C, hw});
         cmd(8'(10 * k));
         dat(8'($urandom), 1);
         dat(8'($urandom), 0);
         dat(8'($urandom), 0);
         sync();
         chk(ptr, p);
      end
      cmd({5'h1C, hw + 3'h1});
      dat(8'h5A, 1);
      sync();
      chk(ptr, p);
      cmd({5'h1C, hw});
      cmd(8'h4E);
      dat(8'hC3, 1);
      dat(8'h3C, 0);
      sync();
      chk({ptr, sub}, {7'(p), 3'(s)});
      // Spill from the previous device lands in our first columns
      cmd({5'h1C, hw - 3'h1});
      cmd(8'h4F);
      dat(8'hA7, 1);
      sync();
      chk({ptr, sub}, {7'(p), 3'(s)});
      cmd({5'h1C, hw});
      cmd(8'hFB);
      cmd(8'd40);
      dat(8'hB5, 1);
      cmd(8'd42);
      dat(8'h6C, 1);
      sync();
      for (int r = 0; r < 3; r++) seg_chk(2'(r));
      cmd(8'hC9);
      cmd(8'hFB);
      cmd(8'd50);
      dat(8'($urandom), 1);
      sync();
      seg_chk(2'h2);
      cmd(8'hFA);
      seg_chk(2'h0);
      cmd(8'hC8);
      for (int r = 0; r < 4; r++) seg_chk(2'(r));
      cmd(8'hC0);
      repeat (20) @(negedge clk);
      chk({don, seg}, 0);
      cmd(8'hC8);
      for (int r = 1; r < 4; r++) begin
         cmd({6'h3C, r[1:0]});
         for (int n = tg + 3, w = 0; tg < n && w < 2000; w++) @(negedge clk);
         chk(half, 4 << (r - 1));
      end
      cmd(8'hC9);
      cmd(8'hF5);
      for (int w = 0; row !== 2'h2 && w < 300; w++) @(negedge clk);
      chk(row, 2'h2);
      cmd(8'hF0);
      give_verdict();
   end
endmodule

// [verif/lcb_master_model.sv]
module lcb_master_model
   import lcb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ready_in,
   input wire logic ack_valid_in,
   input wire logic ack_in,
   output lcb_byte_t byte_out,
   output logic valid_out,
   output logic ack_ready_out
);
   timeunit 1ns;
   timeprecision 1ns;
   lcb_byte_t tx_q[$];
   logic acks_q[$];
   bit stall = 0;
   logic taken = 0;
   initial begin
      byte_out = '0;
      valid_out = 1'b0;
      ack_ready_out = 1'b1;
   end
   // Note takes and collect acks at the sampling edge
   always @(posedge clk_in) begin
      taken <= valid_out && ready_in;
      if (ack_valid_in && ack_ready_out) acks_q.push_back(ack_in);
   end
   // Bytes leave in queued order, control byte first
   always @(negedge clk_in) begin
      ack_ready_out <= !stall || ($urandom % 3 == 0);
      if (rst_in) begin
         valid_out <= 1'b0;
      end else if (!valid_out || taken) begin
         if (tx_q.size() > 0) begin
            byte_out <= tx_q.pop_front();
            valid_out <= 1'b1;
         end else begin
            valid_out <= 1'b0;
            byte_out <= ~byte_out; // Idle lines must not echo the old byte
         end
      end
   end
endmodule

// [verilog/lcb_core.sv]
`include "lcb_regs.svh"
module lcb_core
   import lcb_pkg::*;
#(
   parameter int COLS = `LCB_COLS,
   parameter int DEPTH = `LCB_FIFO_DEPTH,
   parameter int BLINK_DIV = `LCB_BLINK_DIV
) (
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   input wire logic BYTE_VALID_IN,
   input wire logic [7:0] BYTE_DATA_IN,
   input wire logic BYTE_FIRST_IN,
   output logic BYTE_READY_OUT,
   output logic ACK_VALID_OUT,
   output logic ACK_OUT,
   input wire logic ACK_READY_IN,
   input wire logic [2:0] HW_SUBADDR_IN,
   input wire logic CASCADE_LAST_IN,
   input wire logic DISP_TICK_IN,
   output logic [1:0] BACKPLANE_OUTPUT_SEL_OUT,
   output logic [1:0] RAM_ROW_OUT,
   output logic [COLS-1:0] SEGMENT_OUTPUT_OUT,
   output logic DISPLAY_ON_OUT,
   output logic BLINK_PHASE_OUT,
   output logic [1:0] DRIVE_MODE_OUT,
   output logic BIAS_HALF_OUT,
   output logic [6:0] POINTER_OUT,
   output logic [2:0] SUBADDR_OUT
);
   localparam int AW = $clog2(DEPTH);

   // Refuse sizes the pointer and counters cannot hold
   if (COLS < 8 || COLS > 127 || DEPTH < 2 || (1 << AW) != DEPTH ||
       BLINK_DIV < 2 || BLINK_DIV > 1024 || BLINK_DIV % 2 != 0) begin : g_bad
      $error("lcb_core: unsupported parameter value");
   end

   // Input buffer
   lcb_byte_t fifo_q [DEPTH];
   lcb_byte_t fifo_d [DEPTH];
   logic [AW:0] wp_q, wp_d, rp_q, rp_d;
   logic full, empty, push, pop, drain_rdy;
   lcb_byte_t head;

   // Parser and controller state
   lcb_state_t st_q, st_d, st_eff;
   logic last_q, last_d;
   logic drop_q, drop_d;
   lcb_cfg_t cfg_q, cfg_d;
   logic [6:0] ptr_q, ptr_d;
   logic [2:0] sub_q, sub_d;
   logic ack_valid_q, ack_valid_d, ack_q, ack_d;

   // Data write path
   logic [3:0] ram_q [COLS];
   logic [3:0] ram_d [COLS];
   logic [3:0] cols_w, bits_w;
   logic [7:0] sum_w;
   logic here, wrap_hit, wr_en, alt_ok;
   logic [1:0] wr_base;
   logic [7:0] wr_byte;
   int wr_off;

   // Blink and multiplex sequencing
   logic [9:0] div_q, div_d;
   logic [1:0] quad_q, quad_d;
   logic [1:0] row_q, row_d;
   logic phase, swap, show;
   logic [1:0] out_row;
   logic [COLS-1:0] seg_q, seg_d;
   logic [1:0] bp_q, bp_d, rrow_q, rrow_d;
   logic on_q, on_d, ph_q, ph_d;

   // Buffer flags; drain stalls while an ack is unclaimed
   always_comb begin
      full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
      empty = (wp_q == rp_q);
      drain_rdy = !ack_valid_q || ACK_READY_IN;
      push = BYTE_VALID_IN && !full;
      pop = !empty && drain_rdy;
      head = fifo_q[rp_q[AW-1:0]];
      BYTE_READY_OUT = !full;
   end

   // Buffer next state
   always_comb begin
      fifo_d = fifo_q;
      wp_d = wp_q;
      rp_d = rp_q;
      if (push) begin
         fifo_d[wp_q[AW-1:0]] = '{first: BYTE_FIRST_IN, data: BYTE_DATA_IN};
         wp_d = wp_q + 1'b1;
      end
      if (pop) begin
         rp_d = rp_q + 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
      fifo_q <= fifo_d;
   end

   // Per-mode geometry: columns per byte and rows per column
   always_comb begin
      case (cfg_q.mode)
         `LCB_M_STAT: begin
            cols_w = 4'h8;
            bits_w = 4'h1;
         end
         `LCB_M_DUAL: begin
            cols_w = 4'h4;
            bits_w = 4'h2;
         end
         `LCB_M_TRI: begin
            cols_w = 4'h3;
            bits_w = 4'h3;
         end
         default: begin
            cols_w = 4'h2;
            bits_w = 4'h4;
         end
      endcase
      alt_ok = (cfg_q.mode == `LCB_M_STAT) || (cfg_q.mode == `LCB_M_DUAL);
   end

   // Where the next display byte lands
   always_comb begin
      st_eff = head.first ? LCB_ST_CTRL : st_q;
      wr_byte = head.data;
      sum_w = {1'b0, ptr_q} + {4'h0, cols_w};
      here = (sub_q == HW_SUBADDR_IN) && !drop_q;
      // Tail of a byte that overflows the previous device
      wrap_hit = (3'(sub_q + 3'h1) == HW_SUBADDR_IN) &&
                 (sum_w > 8'(COLS));
      wr_en = pop && (st_eff == LCB_ST_DAT) && (here || wrap_hit);
      wr_off = wrap_hit ? int'(ptr_q) - COLS : int'(ptr_q);
      wr_base = (cfg_q.in_bank && alt_ok) ? `LCB_ALT_ROW : 2'h0;
   end

   // Parser, command decoder and controller
   always_comb begin
      st_d = st_q;
      last_d = last_q;
      drop_d = drop_q;
      cfg_d = cfg_q;
      ptr_d = ptr_q;
      sub_d = sub_q;
      ack_valid_d = ack_valid_q && !ACK_READY_IN;
      ack_d = ack_q;
      if (pop) begin
         ack_valid_d = 1'b1;
         ack_d = 1'b1;
         if (head.first) begin
            drop_d = 1'b0;
         end
         case (st_eff)
            LCB_ST_CTRL: begin
               // Select bit routes what follows; continue bit returns here
               last_d = !wr_byte[`LCB_CTRL_MORE];
               st_d = wr_byte[`LCB_CTRL_SEL] ? LCB_ST_DAT : LCB_ST_CMD;
            end
            LCB_ST_CMD: begin
               st_d = last_q ? LCB_ST_CMD : LCB_ST_CTRL;
               if (!wr_byte[7]) begin
                  ptr_d = wr_byte[6:0];
                  drop_d = 1'b0;
               end else if (wr_byte[7:4] == `LCB_OP_MODE) begin
                  cfg_d.disp_en = wr_byte[3];
                  cfg_d.bias_half = wr_byte[2];
                  cfg_d.mode = wr_byte[1:0];
               end else if (wr_byte[7:3] == `LCB_OP_SUB) begin
                  sub_d = wr_byte[2:0];
                  drop_d = 1'b0;
               end else if (wr_byte[7:2] == `LCB_OP_BANK) begin
                  if (alt_ok) begin
                     cfg_d.in_bank = wr_byte[1];
                     cfg_d.out_bank = wr_byte[0];
                  end
               end else if (wr_byte[7:3] == `LCB_OP_BLINK) begin
                  cfg_d.alt_blink = wr_byte[2];
                  cfg_d.rate = wr_byte[1:0];
               end else begin
                  // Any other pattern falls through untouched
                  cfg_d = cfg_q;
               end
            end
            LCB_ST_DAT: begin
               st_d = last_q ? LCB_ST_DAT : LCB_ST_CTRL;
               ack_d = here || wrap_hit;
               // Pointer advances even when storage is inhibited
               if (sum_w >= 8'(COLS)) begin
                  ptr_d = 7'(sum_w - 8'(COLS));
                  sub_d = sub_q + 3'h1;
                  // Last in chain: bits beyond the end are discarded
                  if (here && CASCADE_LAST_IN) begin
                     drop_d = 1'b1;
                  end
               end else begin
                  ptr_d = sum_w[6:0];
               end
            end
            default: begin
               st_d = LCB_ST_CTRL;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         st_q <= LCB_ST_CTRL;
         last_q <= 1'b0;
         drop_q <= 1'b0;
         cfg_q <= `LCB_CFG_RST;
         ptr_q <= '0;
         sub_q <= '0;
         ack_valid_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         st_q <= st_d;
         last_q <= last_d;
         drop_q <= drop_d;
         cfg_q <= cfg_d;
         ptr_q <= ptr_d;
         sub_q <= sub_d;
         ack_valid_q <= ack_valid_d;
         ack_q <= ack_d;
      end
   end

   // Display RAM, one column per iteration
   for (genvar c = 0; c < COLS; c++) begin : g_col
      always_comb begin
         int k;
         int b;
         k = c - wr_off;
         b = 0;
         ram_d[c] = ram_q[c];
         if (wr_en && k >= 0 && k < int'(cols_w)) begin
            for (int j = 0; j < 4; j++) begin
               // MSB first; a negative index leaves the row alone
               b = 7 - int'(bits_w) * k - j;
               if (j < int'(bits_w) && b >= 0) begin
                  ram_d[c][2'(int'(wr_base) + j)] = wr_byte[b[2:0]];
               end
            end
         end
      end
      assign seg_d[c] = ram_q[c][out_row] && show;
      always_ff @(posedge SYS_CLK_IN) begin
         if (SRST_IN) begin
            ram_q[c] <= 4'h0;
         end else begin
            ram_q[c] <= ram_d[c];
         end
      end
   end

   // Blink divider and row walk, both stepped by the display tick
   always_comb begin
      div_d = div_q;
      quad_d = quad_q;
      row_d = row_q;
      if (DISP_TICK_IN) begin
         if (div_q >= 10'(BLINK_DIV - 1)) begin
            div_d = 10'h000;
            quad_d = quad_q + 2'h1;
         end else begin
            div_d = div_q + 10'h001;
         end
         // A mode change mid-frame can leave the row out of range
         if ({2'h0, row_q} >= bits_w - 4'h1) begin
            row_d = 2'h0;
         end else begin
            row_d = row_q + 2'h1;
         end
      end
   end

   // Blink phase, bank swap, blanking and selected row
   always_comb begin
      case (cfg_q.rate)
         2'h1: phase = div_q >= 10'(BLINK_DIV / 2);
         2'h2: phase = quad_q[0];
         2'h3: phase = quad_q[1];
         default: phase = 1'b0;
      endcase
      swap = cfg_q.alt_blink && alt_ok && phase;
      // Alternate-bank blinking never blanks; it swaps banks in static and 1:2 modes only
      show = cfg_q.disp_en && !(phase && !cfg_q.alt_blink);
      out_row = row_q;
      if (alt_ok && (cfg_q.out_bank ^ swap)) begin
         out_row = row_q + `LCB_ALT_ROW;
      end
      bp_d = row_d;
      rrow_d = out_row;
      on_d = show;
      ph_d = phase;
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         div_q <= '0;
         quad_q <= '0;
         row_q <= '0;
         seg_q <= '0;
         bp_q <= '0;
         rrow_q <= '0;
         on_q <= 1'b0;
         ph_q <= 1'b0;
      end else begin
         div_q <= div_d;
         quad_q <= quad_d;
         row_q <= row_d;
         seg_q <= seg_d;
         bp_q <= bp_d;
         rrow_q <= rrow_d;
         on_q <= on_d;
         ph_q <= ph_d;
      end
   end

   // Outputs from flops; segment data lags the row by one cycle
   assign ACK_VALID_OUT = ack_valid_q;
   assign ACK_OUT = ack_q;
   assign BACKPLANE_OUTPUT_SEL_OUT = bp_q;
   assign RAM_ROW_OUT = rrow_q;
   assign SEGMENT_OUTPUT_OUT = seg_q;
   assign DISPLAY_ON_OUT = on_q;
   assign BLINK_PHASE_OUT = ph_q;
   assign DRIVE_MODE_OUT = cfg_q.mode;
   assign BIAS_HALF_OUT = cfg_q.bias_half;
   assign POINTER_OUT = ptr_q;
   assign SUBADDR_OUT = sub_q;
endmodule

// [verilog/lcb_pkg.sv]
package lcb_pkg;
   typedef enum logic [2:0] {
      LCB_ST_CTRL = 3'b001,
      LCB_ST_CMD = 3'b010,
      LCB_ST_DAT = 3'b100
   } lcb_state_t;
   typedef struct packed {
      logic first;
      logic [7:0] data;
   } lcb_byte_t;
   typedef struct packed {
      logic disp_en;
      logic bias_half;
      logic [1:0] mode;
      logic in_bank;
      logic out_bank;
      logic alt_blink;
      logic [1:0] rate;
   } lcb_cfg_t;
endpackage

// [verilog/lcb_regs.svh]
`ifndef LCB_REGS_SVH
`define LCB_REGS_SVH
`define LCB_COLS 80
`define LCB_FIFO_DEPTH 2
`define LCB_BLINK_DIV 768
`define LCB_CTRL_MORE 7
`define LCB_CTRL_SEL 6
`define LCB_OP_MODE 4'hC
`define LCB_OP_SUB 5'h1C
`define LCB_OP_BANK 6'h3E
`define LCB_OP_BLINK 5'h1E
`define LCB_M_STAT 2'b01
`define LCB_M_DUAL 2'b10
`define LCB_M_TRI 2'b11
`define LCB_M_QUAD 2'b00
`define LCB_ALT_ROW 2'h2
`define LCB_CFG_RST 9'h000
`endif
